/* File: rtl/cidp_pkg.sv */
// Constants shared by the configuration index/data port logic
package cidp_pkg;
	// Configuration keys
	localparam logic [7:0] KEY_ENTER = 8'h55;
	localparam logic [7:0] KEY_EXIT = 8'hAA;
	// Register indices: global ones, plus the per-device activate register
	localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
	localparam logic [7:0] IDX_LDEV_SEL = 8'h07;
	localparam logic [7:0] IDX_BASE_LOW = 8'h26;
	localparam logic [7:0] IDX_BASE_HIGH = 8'h27;
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam int SOFT_RESET_BIT = 0;
	localparam int ACTIVATE_BIT = 0;
	// Strap-selected base address bytes
	localparam logic [7:0] BASE_LOW_STRAP0 = 8'h2E;
	localparam logic [7:0] BASE_LOW_STRAP1 = 8'h4E;
	localparam logic [7:0] BASE_HIGH_STRAP0 = 8'h16;
	localparam logic [7:0] BASE_HIGH_STRAP1 = 8'h00;
	// Reset values
	localparam logic [7:0] LDEV_SEL_RESET = 8'h00;
	// Logical device numbers
	localparam logic [7:0] LDEV_FLOPPY = 8'h00;
	localparam logic [7:0] LDEV_PARALLEL = 8'h03;
	localparam logic [7:0] LDEV_SERIAL1 = 8'h04;
	localparam logic [7:0] LDEV_SERIAL2 = 8'h05;
	localparam logic [7:0] LDEV_KEYBOARD = 8'h07;
	localparam int LDEV_COUNT = 8;
	// Timing
	localparam int CLOCK_MHZ = 250;
	localparam int POWERUP_BLOCK_US = 500;
	localparam int POWERUP_BLOCK_CYCLES = POWERUP_BLOCK_US * CLOCK_MHZ;
	// Controller states
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_CONFIG = 2'b10
	} cidp_state_e;
endpackage : cidp_pkg

/* File: rtl/cidp_config_port.sv */
// Configuration port state machine and global/logical-device registers
// Operation
// [RL1] Reset gives Run state, all devices disabled
// [RL2] Low strap latched at reset release: 2E/4E
// [RL3] High strap latched at reset release: 16/00
// [RL4] Index at base, data at base plus one
// [RL5] Registers 26h/27h relocate the base address
// [RL6] Key 55h enters Configuration, opens ports
// [RL7] Key AAh returns device to Run
// [RL8] Index/data ignored while in Run
// [RL9] Host selects device via index 07h first
// [RL10] Global registers reachable without device select
// [RL11] Only Run and Configuration; Run accepts key
// [RL12] Control bit 0 write triggers soft reset
// [RL13] Host access blocked 500us after power-on
// [RL14] Host sequence: enter, access, exit
// [RL15] Device numbers 0,3,4,5,7 valid; rest reserved
// [RL16] Unimplemented registers ignore writes, read zero
// [RL17] Soft reset bit clears itself
// [RL18] Activate applies only to selected device
// [RL19] Run-state non-key write changes nothing
module cidp_config_port
	import cidp_pkg::*;
#(
	parameter int BLOCK_CYCLES = POWERUP_BLOCK_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic host_bus_reset_n,
	input wire logic base_low_strap,
	input wire logic base_high_strap,
	input wire logic [15:0] ioAddr,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [7:0] ioWrData,
	output logic [7:0] ioRdData,
	output logic ioRdHit,
	output logic configMode,
	output logic accessBlocked,
	output logic [15:0] configBase,
	output logic [7:0] currentDevice,
	output logic [LDEV_COUNT-1:0] deviceActive
);
	localparam int CW = $clog2(BLOCK_CYCLES + 1);
	// Elaboration check: a zero count would never block anything
	if (BLOCK_CYCLES < 1) begin : g_bad_block
		$error("BLOCK_CYCLES must be at least one");
	end

	// Host bus reset is a pin: three flops, change counts on agreement
	logic [2:0] hrstSync_reg, hrstSync_next;
	logic hrstStable_reg, hrstStable_next;
	always_comb begin
		hrstSync_next = {hrstSync_reg[1:0], host_bus_reset_n};
		hrstStable_next = hrstStable_reg;
		if (hrstSync_reg[2] == hrstSync_reg[1]) begin
			hrstStable_next = hrstSync_reg[1];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hrstSync_reg <= 3'h0;
			hrstStable_reg <= 1'b0;
		end else begin
			hrstSync_reg <= hrstSync_next;
			hrstStable_reg <= hrstStable_next;
		end
	end
	logic busReset;
	logic busRelease;
	assign busReset = !hrstStable_reg;
	assign busRelease = hrstStable_next && !hrstStable_reg;

	// Straps also come from pins and are synchronised the same way
	logic [2:0] lowSync_reg, lowSync_next, highSync_reg, highSync_next;
	logic lowStable_reg, lowStable_next, highStable_reg, highStable_next;
	always_comb begin
		lowSync_next = {lowSync_reg[1:0], base_low_strap};
		highSync_next = {highSync_reg[1:0], base_high_strap};
		lowStable_next = (lowSync_reg[2] == lowSync_reg[1]) ? lowSync_reg[1] : lowStable_reg;
		highStable_next = (highSync_reg[2] == highSync_reg[1]) ? highSync_reg[1] : highStable_reg;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lowSync_reg <= 3'h0;
			highSync_reg <= 3'h0;
			lowStable_reg <= 1'b0;
			highStable_reg <= 1'b0;
		end else begin
			lowSync_reg <= lowSync_next;
			highSync_reg <= highSync_next;
			lowStable_reg <= lowStable_next;
			highStable_reg <= highStable_next;
		end
	end

	// Power-on block counter; straps are caught on the clocked release
	logic [CW-1:0] blockCnt_reg, blockCnt_next;
	logic strapPending_reg, strapPending_next;
	always_comb begin
		blockCnt_next = blockCnt_reg;
		if (blockCnt_reg != '0) begin
			blockCnt_next = blockCnt_reg - 1'b1; // see [RL13]
		end
		strapPending_next = 1'b0;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			blockCnt_reg <= CW'(BLOCK_CYCLES);
			strapPending_reg <= 1'b1;
		end else begin
			blockCnt_reg <= blockCnt_next;
			strapPending_reg <= strapPending_next;
		end
	end
	assign accessBlocked = (blockCnt_reg != '0); // see [RL13]

	// Address decode; host cycles are dropped while blocked or in bus reset
	logic hostOk;
	logic hitCfg, hitData;
	assign hostOk = !accessBlocked && !busReset;
	assign hitCfg = hostOk && (ioAddr == configBase);
	assign hitData = hostOk && (ioAddr == configBase + 16'h0001); // see [RL4]

	// Controller state, index, and configuration registers
	cidp_state_e state_reg, state_next;
	logic [7:0] index_reg, index_next;
	logic [7:0] ldev_reg, ldev_next;
	logic [7:0] baseLow_reg, baseLow_next, baseHigh_reg, baseHigh_next;
	logic [LDEV_COUNT-1:0] active_reg, active_next;
	logic strapLoad;
	logic softReset;
	logic validDev;
	assign strapLoad = strapPending_reg || busRelease;
	assign validDev = (ldev_reg == LDEV_FLOPPY) || (ldev_reg == LDEV_PARALLEL)
		|| (ldev_reg == LDEV_SERIAL1) || (ldev_reg == LDEV_SERIAL2)
		|| (ldev_reg == LDEV_KEYBOARD); // see [RL15]
	// Soft reset is a pulse, so bit 0 of control never holds a one
	assign softReset = (state_reg == ST_CONFIG) && ioWrite && hitData
		&& (index_reg == IDX_CFG_CTRL) && ioWrData[SOFT_RESET_BIT]; // see [RL12] [RL17]

	always_comb begin
		state_next = state_reg;
		index_next = index_reg;
		ldev_next = ldev_reg;
		baseLow_next = baseLow_reg;
		baseHigh_next = baseHigh_reg;
		active_next = active_reg;
		unique case (state_reg)
			ST_RUN: begin
				// Only the entry key is heard in Run
				if (ioWrite && hitCfg && ioWrData == KEY_ENTER) begin
					state_next = ST_CONFIG; // see [RL6] [RL11] [RL19]
				end
			end
			ST_CONFIG: begin
				if (ioWrite && hitCfg) begin
					// Index port shares the config port address
					if (ioWrData == KEY_EXIT) begin
						state_next = ST_RUN; // see [RL7]
					end else begin
						index_next = ioWrData; // see [RL4]
					end
				end else if (ioWrite && hitData) begin
					// Global registers need no device select
					unique case (index_reg)
						IDX_LDEV_SEL: ldev_next = ioWrData; // see [RL9] [RL10]
						IDX_BASE_LOW: baseLow_next = ioWrData; // see [RL5]
						IDX_BASE_HIGH: baseHigh_next = ioWrData; // see [RL5]
						IDX_ACTIVATE: begin
							if (validDev) begin
								active_next[ldev_reg[2:0]] = ioWrData[ACTIVATE_BIT]; // see [RL18]
							end
						end
						default: begin
						end // see [RL16]
					endcase
				end
			end
		endcase
		if (softReset) begin
			ldev_next = LDEV_SEL_RESET; // see [RL12]
			active_next = '0;
		end
		// Strap load wins; relocated base is lost on a bus reset
		// Next values are used: the stable flops lag the release by one edge
		if (strapLoad) begin
			baseLow_next = lowStable_next ? BASE_LOW_STRAP1 : BASE_LOW_STRAP0; // see [RL2]
			baseHigh_next = highStable_next ? BASE_HIGH_STRAP1 : BASE_HIGH_STRAP0; // see [RL3]
		end
		if (busReset) begin
			state_next = ST_RUN; // see [RL1]
			index_next = 8'h00;
			ldev_next = LDEV_SEL_RESET;
			active_next = '0;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_RUN; // see [RL1]
			index_reg <= 8'h00;
			ldev_reg <= LDEV_SEL_RESET;
			baseLow_reg <= BASE_LOW_STRAP0;
			baseHigh_reg <= BASE_HIGH_STRAP0;
			active_reg <= '0;
		end else begin
			state_reg <= state_next;
			index_reg <= index_next;
			ldev_reg <= ldev_next;
			baseLow_reg <= baseLow_next;
			baseHigh_reg <= baseHigh_next;
			active_reg <= active_next;
		end
	end

	// Read data is registered; misses and Run-state reads return zero
	logic [7:0] rdData_reg, rdData_next;
	logic rdHit_reg, rdHit_next;
	always_comb begin
		rdData_next = 8'h00;
		rdHit_next = 1'b0;
		if (ioRead && state_reg == ST_CONFIG && (hitCfg || hitData)) begin // see [RL8]
			rdHit_next = 1'b1;
			if (hitCfg) begin
				rdData_next = index_reg;
			end else begin
				unique case (index_reg)
					IDX_LDEV_SEL: rdData_next = ldev_reg;
					IDX_BASE_LOW: rdData_next = baseLow_reg;
					IDX_BASE_HIGH: rdData_next = baseHigh_reg;
					IDX_ACTIVATE: rdData_next = validDev
						? {7'h00, active_reg[ldev_reg[2:0]]} : 8'h00;
					default: rdData_next = 8'h00; // see [RL16]
				endcase
			end
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdData_reg <= 8'h00;
			rdHit_reg <= 1'b0;
		end else begin
			rdData_reg <= rdData_next;
			rdHit_reg <= rdHit_next;
		end
	end

	assign ioRdData = rdData_reg;
	assign ioRdHit = rdHit_reg;
	assign configMode = (state_reg == ST_CONFIG);
	assign configBase = {baseHigh_reg, baseLow_reg};
	assign currentDevice = ldev_reg;
	assign deviceActive = active_reg;
endmodule : cidp_config_port

/* File: dv/cidp_host.sv */
// Host model issuing I/O cycles to the configuration port
module cidp_host
	import cidp_pkg::*;
(
	input wire logic clock,
	input wire logic [7:0] ioRdData,
	input wire logic ioRdHit,
	output logic [15:0] ioAddr,
	output logic ioWrite,
	output logic ioRead,
	output logic [7:0] ioWrData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ioAddr = 16'h0000;
		ioWrite = 1'b0;
		ioRead = 1'b0;
		ioWrData = 8'h00;
	end
	// Idle lines show inverted values so stale data never passes
	task wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge clock);
		ioAddr = a;
		ioWrData = v;
		ioWrite = 1'b1;
		@(negedge clock);
		ioWrite = 1'b0;
		ioAddr = ~a;
		ioWrData = ~v;
	endtask : wr
	// Answer is taken the cycle after the strobe
	task rd(input logic [15:0] a, output logic h, output logic [7:0] v);
		@(negedge clock);
		ioAddr = a;
		ioRead = 1'b1;
		@(negedge clock);
		ioRead = 1'b0;
		ioAddr = ~a;
		h = ioRdHit;
		v = ioRdData;
	endtask : rd
	// Index first, then data through the next port
	task cfg(input logic [15:0] b, input logic [7:0] i, input logic [7:0] v);
		wr(b, i);
		wr(b + 16'h0001, v);
	endtask : cfg
endmodule : cidp_host

/* File: dv/cidp_config_port_chk.sv */
// Assertions on the configuration port block
module cidp_config_port_chk
	import cidp_pkg::*;
#(
	parameter int BLOCK_CYCLES = POWERUP_BLOCK_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic host_bus_reset_n,
	input wire logic [15:0] ioAddr,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [7:0] ioWrData,
	input wire logic ioRdHit,
	input wire logic configMode,
	input wire logic accessBlocked,
	input wire logic [15:0] configBase,
	input wire logic [7:0] currentDevice,
	input wire logic [7:0] deviceActive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] busHist_reg;
	logic [5:0] busHist_next;
	int cnt_reg;
	int cnt_next;
	logic ok;
	logic portHit;
	logic dataHit;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Bus reset history covers the synchroniser delay
	always_comb begin
		busHist_next = {busHist_reg[4:0], host_bus_reset_n};
		cnt_next = cnt_reg + ((cnt_reg <= BLOCK_CYCLES) ? 1 : 0);
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busHist_reg <= '0;
			cnt_reg <= 0;
		end else begin
			busHist_reg <= busHist_next;
			cnt_reg <= cnt_next;
		end
	end
	assign ok = &busHist_reg && !accessBlocked;
	assign portHit = ioWrite && ok && ioAddr == configBase;
	assign dataHit = ioWrite && ok && ioAddr == configBase + 16'h0001;
	sequence sIdx(logic [7:0] i);
		configMode && portHit && ioWrData == i ##2 configMode && dataHit;
	endsequence
	enter_key_a: assert property (!configMode && portHit && ioWrData == KEY_ENTER |=> configMode)
		else $error("entry key ignored");
	exit_key_a: assert property (configMode && portHit && ioWrData == KEY_EXIT |=> !configMode)
		else $error("exit key ignored");
	run_hold_a: assert property (!configMode && !(portHit && ioWrData == KEY_ENTER) |=> !configMode)
		else $error("run state left without key");
	run_read_a: assert property (!configMode |=> !ioRdHit)
		else $error("read claimed in run state");
	read_hit_a: assert property (configMode && ioRead && ok &&
		(ioAddr == configBase || ioAddr == configBase + 16'h0001) |=> ioRdHit)
		else $error("port read not claimed");
	dev_sel_a: assert property (sIdx(IDX_LDEV_SEL) |=> currentDevice == $past(ioWrData))
		else $error("device select not taken");
	soft_rst_a: assert property (sIdx(IDX_CFG_CTRL) ##0 ioWrData[SOFT_RESET_BIT] |=>
		currentDevice == 8'h00 && deviceActive == 8'h00)
		else $error("soft reset missed");
	base_low_a: assert property (sIdx(IDX_BASE_LOW) |=> configBase[7:0] == $past(ioWrData))
		else $error("base not relocated");
	bus_rst_a: assert property (!host_bus_reset_n [*6] |-> !configMode && deviceActive == 8'h00)
		else $error("bus reset not applied");
	block_time_a: assert property (cnt_reg < BLOCK_CYCLES |-> accessBlocked)
		else $error("block ended early");
	unblock_a: assert property (cnt_reg >= BLOCK_CYCLES |-> !accessBlocked)
		else $error("block ended late");
endmodule : cidp_config_port_chk
bind cidp_config_port cidp_config_port_chk #(.BLOCK_CYCLES(BLOCK_CYCLES)) i_chk (
	.clock(clock), .rst_n(rst_n), .host_bus_reset_n(host_bus_reset_n), .ioAddr(ioAddr),
	.ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdHit(ioRdHit),
	.configMode(configMode), .accessBlocked(accessBlocked), .configBase(configBase),
	.currentDevice(currentDevice), .deviceActive(deviceActive));

/* File: dv/testbench.sv */
// Self-checking bench for the configuration port block
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench import cidp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst_n, host_bus_reset_n, base_low_strap, base_high_strap;
	logic [15:0] ioAddr, configBase, b;
	logic ioWrite, ioRead, ioRdHit, configMode, accessBlocked, h;
	logic [7:0] ioWrData, ioRdData, currentDevice, deviceActive, d;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	cidp_config_port #(.BLOCK_CYCLES(20)) i_cidp_config_port (.clock(clock), .rst_n(rst_n),
		.host_bus_reset_n(host_bus_reset_n), .base_low_strap(base_low_strap),
		.base_high_strap(base_high_strap), .ioAddr(ioAddr), .ioWrite(ioWrite),
		.ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdHit(ioRdHit),
		.configMode(configMode), .accessBlocked(accessBlocked), .configBase(configBase),
		.currentDevice(currentDevice), .deviceActive(deviceActive));
	cidp_host i_cidp_host (.clock(clock), .ioRdData(ioRdData), .ioRdHit(ioRdHit),
		.ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData));
	always #2 clock = ~clock;
	// Hang guard, far above the fewer than two hundred cycles needed
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			end_sim();
		end
	end
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	// Straps settle through the synchronisers, so the base is judged after the block
	task t_powerup;
		`CHK("blocked", 1'b1, accessBlocked)
		i_cidp_host.wr(b, KEY_ENTER);
		`CHK("blocked key", 1'b0, configMode)
		for (int i = 0; i < 40 && accessBlocked; i++) @(negedge clock);
		`CHK("unblock", 1'b0, accessBlocked)
		`CHK("base", b, configBase)
		`CHK("mode", 1'b0, configMode)
		`CHK("act", 8'h00, deviceActive)
		$display("powerup done");
	endtask : t_powerup
	task t_keys;
		i_cidp_host.wr(b, KEY_EXIT);
		`CHK("run other", 1'b0, configMode)
		i_cidp_host.rd(b, h, d);
		`CHK("run read", 1'b0, h)
		i_cidp_host.wr(b, KEY_ENTER);
		`CHK("enter", 1'b1, configMode)
		i_cidp_host.rd(b + 16'h0001, h, d);
		`CHK("data hit", 1'b1, h)
		`CHK("data rd", 8'h00, d)
		i_cidp_host.wr(b, KEY_EXIT);
		`CHK("exit", 1'b0, configMode)
		i_cidp_host.wr(b + 16'h0001, KEY_ENTER);
		`CHK("key at data", 1'b0, configMode)
		$display("keys done");
	endtask : t_keys
	task t_devices;
		logic [7:0] e;
		e = 8'h00;
		i_cidp_host.wr(b, KEY_ENTER);
		for (int i = 0; i < LDEV_COUNT; i++) begin
			i_cidp_host.cfg(b, IDX_LDEV_SEL, i[7:0]);
			`CHK("dev", i[7:0], currentDevice)
			i_cidp_host.cfg(b, IDX_ACTIVATE, 8'h01);
			if (i[7:0] inside {LDEV_FLOPPY, LDEV_PARALLEL, LDEV_SERIAL1,
				LDEV_SERIAL2, LDEV_KEYBOARD}) e[i] = 1'b1;
			`CHK("active", e, deviceActive)
			i_cidp_host.rd(b + 16'h0001, h, d);
			`CHK("act read", 8'(e[i]), d)
		end
		$display("devices done");
	endtask : t_devices
	task t_soft;
		i_cidp_host.cfg(b, IDX_CFG_CTRL, 8'h01);
		`CHK("soft dev", 8'h00, currentDevice)
		`CHK("soft act", 8'h00, deviceActive)
		i_cidp_host.rd(b + 16'h0001, h, d);
		`CHK("ctrl read", 8'h00, d)
		i_cidp_host.cfg(b, 8'h03, 8'hFF);
		i_cidp_host.rd(b + 16'h0001, h, d);
		`CHK("unimpl", 8'h00, d)
		$display("soft done");
	endtask : t_soft
	task t_reloc;
		i_cidp_host.cfg(b, IDX_BASE_LOW, 8'h70);
		b = {b[15:8], 8'h70};
		`CHK("base low", b, configBase)
		i_cidp_host.cfg(b, IDX_BASE_HIGH, 8'h03);
		b = 16'h0370;
		`CHK("base high", b, configBase)
		i_cidp_host.rd(b + 16'h0001, h, d);
		`CHK("base read", 8'h03, d)
		i_cidp_host.rd(b, h, d);
		`CHK("index read", IDX_BASE_HIGH, d)
		i_cidp_host.wr(b, KEY_EXIT);
		`CHK("new base exit", 1'b0, configMode)
		$display("reloc done");
	endtask : t_reloc
	task t_busrst;
		i_cidp_host.wr(b, KEY_ENTER);
		base_low_strap = 1'b0;
		base_high_strap = 1'b1;
		host_bus_reset_n = 1'b0;
		repeat (8) @(negedge clock);
		`CHK("bus mode", 1'b0, configMode)
		host_bus_reset_n = 1'b1;
		repeat (8) @(negedge clock);
		b = {BASE_HIGH_STRAP1, BASE_LOW_STRAP0};
		`CHK("strap base", b, configBase)
		i_cidp_host.wr(b, KEY_ENTER);
		`CHK("reenter", 1'b1, configMode)
		$display("busrst done");
	endtask : t_busrst
	initial begin
		rst_n = 1'b0;
		host_bus_reset_n = 1'b1;
		base_low_strap = 1'b1;
		base_high_strap = 1'b0;
		b = {BASE_HIGH_STRAP0, BASE_LOW_STRAP1};
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		@(negedge clock);
		t_powerup();
		t_keys();
		t_devices();
		t_soft();
		t_reloc();
		t_busrst();
		end_sim();
	end
endmodule : testbench
